// [rtl/dsk_seek.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dsk_seek_map.svh"
// What this block does
// - Load desired cylinder on select+write, idle only
// - Subtract cylinders; forward gives direction low
// - Desired below current asserts reverse direction
// - Equal cylinders give zero difference, no seek
// - Mux difference with offset onto drive lines
// - All-zero difference asserts cylinders equal
// - Ready reassertion copies desired into current
// - Increment cylinder after last track, issue go
// - Increment past top cylinder sets overflow error
// - Writing cylinder above top sets invalid error
// - Header word one cylinder compare gives match
// - Track field drives five head-select lines
// - Load sector/track on select plus write
// - Busy: increment track after final sector
// - Track 18 detected, then wraps to zero
// - Header word two track/sector compare match
// - Desired sector equals counter gives sector match
// - Increment sector on end-of-block while busy
// - Final sector clears sector field after transfer
// - Data gap end clears sector-area flag
// - Write data gap end: clear write flag, pulse EOB
module dsk_seek (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic desiredCylinderSelect,
  input wire logic sectorTrackSelect,
  input wire logic registerWriteStrobe,
  input wire logic [`DSK_WD_W-1:0] writeData,
  input wire logic commandInProgress,
  input wire logic driveReadyPin,
  input wire logic [`DSK_CYL_W-1:0] offsetValue,
  input wire logic offsetSelect,
  input wire logic transferDone,
  input wire logic dataGapEnd,
  input wire logic writeOp,
  input wire logic sectorAreaStart,
  input wire logic writeSectorStart,
  input wire logic finalSectorOfTrack,
  input wire logic headerWord1Valid,
  input wire logic headerWord2Valid,
  input wire logic [`DSK_WD_W-1:0] headerWord,
  input wire logic [`DSK_SEC_W-1:0] sectorCount,
  input wire logic errorClear,
  output logic [`DSK_CYL_W-1:0] cylinderDifference,
  output logic seekDirectionReverse,
  output logic cylindersEqual,
  output logic sectorFoundEnable,
  output logic seekGo,
  output logic currentCylinderLoadClock,
  output logic [`DSK_CYL_W-1:0] desiredCylinder,
  output logic [`DSK_CYL_W-1:0] currentCylinder,
  output logic [`DSK_TRK_W-1:0] headSelect,
  output logic [`DSK_SEC_W-1:0] desiredSector,
  output logic finalTrackDetect,
  output dsk_seek_pkg::dsk_err_t errorFlags,
  output logic cylinderMatch,
  output logic sectorTrackMatch,
  output logic sectorMatch,
  output logic endOfBlockPulse,
  output logic sectorAreaFlag,
  output logic writeSectorFlag
);
  import dsk_seek_pkg::*;

  // Ready pin synchroniser; first stage read only by second
  logic readyMeta;
  logic readySync;
  logic readyLast;
  // Desired sector/track register
  dsk_sectrk_t sectTrk;
  // Raw subtract result, one extra bit for the borrow
  logic [`DSK_CYL_W:0] diffRaw;
  logic cylLoad;
  logic stLoad;
  logic trackAdvance;
  logic readyRise;
  logic [`DSK_CYL_W-1:0] nextCyl;

  // Pin synchroniser, two flops before use
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // Idle ready is high; a low reset value would fake a rise
      readyMeta <= 1'b1;
      readySync <= 1'b1;
      readyLast <= 1'b1;
    end else begin
      readyMeta <= driveReadyPin;
      readySync <= readyMeta;
      readyLast <= readySync;
    end
  end

  // Drive relies on dropping ready while seeking
  assign readyRise = readySync & ~readyLast;

  // Cylinder register writes are refused while a command runs; sector/track writes are not
  assign cylLoad = desiredCylinderSelect & registerWriteStrobe
    & ~commandInProgress;
  assign stLoad = sectorTrackSelect & registerWriteStrobe;

  // Track moves on after the final sector or transfer end
  assign trackAdvance = commandInProgress & endOfBlockPulse
    & (finalSectorOfTrack | transferDone);
  assign nextCyl = desiredCylinder + `DSK_CYL_ONE;

  // Desired cylinder: software load or mid-transfer increment
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      desiredCylinder <= `DSK_CYL_ZERO;
    end else if (cylLoad) begin
      desiredCylinder <= writeData[`DSK_CYL_W-1:0];
    end else if (trackAdvance && finalTrackDetect) begin
      desiredCylinder <= nextCyl;
    end
  end

  // Seek go pulses whenever the cylinder steps mid-transfer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seekGo <= 1'b0;
    end else begin
      seekGo <= trackAdvance & finalTrackDetect;
    end
  end

  // Current cylinder takes desired when the drive ready rises
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      currentCylinder <= `DSK_CYL_ZERO;
      currentCylinderLoadClock <= 1'b0;
    end else begin
      currentCylinderLoadClock <= readyRise;
      if (readyRise) begin
        currentCylinder <= desiredCylinder;
      end
    end
  end

  // Subtract; borrow means reverse motion
  assign diffRaw = {1'b0, desiredCylinder} - {1'b0, currentCylinder};

  // Direction and magnitude, registered toward the drive
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seekDirectionReverse <= 1'b0;
      cylinderDifference <= `DSK_CYL_ZERO;
      cylindersEqual <= 1'b1;
    end else begin
      seekDirectionReverse <= diffRaw[`DSK_CYL_W];
      // Offset shares the difference lines
      if (offsetSelect) begin
        cylinderDifference <= offsetValue;
      end else if (diffRaw[`DSK_CYL_W]) begin
        cylinderDifference <= currentCylinder - desiredCylinder;
      end else begin
        cylinderDifference <= diffRaw[`DSK_CYL_W-1:0];
      end
      cylindersEqual <= (diffRaw == `DSK_DIFF_ZERO);
    end
  end

  // Heads on cylinder allow the sector-found flop to clock
  assign sectorFoundEnable = cylindersEqual;

  // Error flags: set beats clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      errorFlags <= '0;
    end else begin
      if (trackAdvance && finalTrackDetect
          && desiredCylinder >= `DSK_CYL_MAX) begin
        errorFlags.addrOverflow <= 1'b1;
      end else if (errorClear) begin
        errorFlags.addrOverflow <= 1'b0;
      end
      if (cylLoad && writeData[`DSK_CYL_W-1:0] > `DSK_CYL_MAX) begin
        errorFlags.invalidAddr <= 1'b1;
      end else if (errorClear) begin
        errorFlags.invalidAddr <= 1'b0;
      end
    end
  end

  // Sector/track register: load, sector step, track step
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sectTrk <= '0;
    end else if (stLoad) begin
      sectTrk.track <=
        writeData[`DSK_TRK_LSB+`DSK_TRK_W-1:`DSK_TRK_LSB];
      sectTrk.sector <= writeData[`DSK_SEC_W-1:0];
    end else if (trackAdvance) begin
      sectTrk.sector <= `DSK_SEC_ZERO;
      if (finalTrackDetect) begin
        sectTrk.track <= `DSK_TRK_ZERO;
      end else begin
        sectTrk.track <= sectTrk.track + `DSK_TRK_ONE;
      end
    end else if (commandInProgress && endOfBlockPulse) begin
      sectTrk.sector <= sectTrk.sector + `DSK_SEC_ONE;
    end
  end

  // Head select needs no motion, just the track field
  assign headSelect = sectTrk.track;
  assign desiredSector = sectTrk.sector;
  assign finalTrackDetect = (sectTrk.track == `DSK_TRK_LAST);

  // Header and sector compares, registered
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cylinderMatch <= 1'b0;
      sectorTrackMatch <= 1'b0;
      sectorMatch <= 1'b0;
    end else begin
      if (headerWord1Valid) begin
        cylinderMatch <= (headerWord[`DSK_CYL_W-1:0]
          == desiredCylinder);
      end
      if (headerWord2Valid) begin
        sectorTrackMatch <=
          (headerWord[`DSK_TRK_LSB+`DSK_TRK_W-1:`DSK_TRK_LSB]
          == sectTrk.track)
          && (headerWord[`DSK_SEC_W-1:0] == sectorCount);
      end
      sectorMatch <= (sectTrk.sector == sectorCount);
    end
  end

  // Sector flags and end-of-block pulse at data gap end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sectorAreaFlag <= 1'b0;
      writeSectorFlag <= 1'b0;
      endOfBlockPulse <= 1'b0;
    end else begin
      endOfBlockPulse <= dataGapEnd;
      // Start wins over the end of the gap
      if (sectorAreaStart) begin
        sectorAreaFlag <= 1'b1;
      end else if (dataGapEnd) begin
        sectorAreaFlag <= 1'b0;
      end
      if (writeSectorStart) begin
        writeSectorFlag <= 1'b1;
      end else if (dataGapEnd && writeOp) begin
        writeSectorFlag <= 1'b0;
      end
    end
  end

  // Checks and covers share the device clock and reset
  default clocking chkClk @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Direction follows the sign of the subtraction
  chk_fwd_dir: assert property (
    desiredCylinder >= currentCylinder |=> !seekDirectionReverse)
    else $error("forward seek flagged reverse");
  chk_rev_dir: assert property (
    desiredCylinder < currentCylinder |=> seekDirectionReverse)
    else $error("reverse seek not flagged");
  // Zero magnitude on cylinder, unless the offset owns the lines
  chk_eq_zero: assert property (
    desiredCylinder == currentCylinder && !offsetSelect
    |=> cylindersEqual && cylinderDifference == `DSK_CYL_ZERO)
    else $error("equal cylinders not zero");
  chk_off_mux: assert property (
    offsetSelect |=> cylinderDifference == $past(offsetValue))
    else $error("offset not on drive lines");
  chk_eq_flag: assert property (
    cylindersEqual && !$past(offsetSelect)
    |-> cylinderDifference == `DSK_CYL_ZERO)
    else $error("equal flag with nonzero difference");
  // Current cylinder takes the desired one at the load pulse
  chk_ccload_copy: assert property (
    currentCylinderLoadClock |-> currentCylinder == $past(desiredCylinder))
    else $error("current cylinder not copied");
  // Busy refuses a cylinder write; only the step may move it
  chk_load_gate: assert property (
    desiredCylinderSelect && registerWriteStrobe && commandInProgress
    && !(trackAdvance && finalTrackDetect)
    |=> $stable(desiredCylinder))
    else $error("cylinder loaded while busy");
  chk_go_step: assert property (
    seekGo |-> desiredCylinder == $past(desiredCylinder) + `DSK_CYL_ONE)
    else $error("seek go without cylinder step");
  // Overflow on the step past the top, invalid on a bad write
  chk_ovf_set: assert property (
    trackAdvance && finalTrackDetect && desiredCylinder >= `DSK_CYL_MAX
    |=> errorFlags.addrOverflow)
    else $error("address overflow missed");
  chk_inv_addr: assert property (
    cylLoad && writeData[`DSK_CYL_W-1:0] > `DSK_CYL_MAX
    |=> errorFlags.invalidAddr)
    else $error("invalid address missed");
  // Header and sector compares land one cycle later
  chk_cyl_match: assert property (
    headerWord1Valid && headerWord[`DSK_CYL_W-1:0] == desiredCylinder
    |=> cylinderMatch)
    else $error("cylinder match missed");
  chk_st_match: assert property (
    headerWord2Valid && headerWord[`DSK_SEC_W-1:0] == sectorCount
    && headerWord[`DSK_TRK_LSB+`DSK_TRK_W-1:`DSK_TRK_LSB] == headSelect
    |=> sectorTrackMatch)
    else $error("sector/track match missed");
  chk_sec_match: assert property (
    desiredSector == sectorCount |=> sectorMatch)
    else $error("sector match missed");
  // Sector/track register: load, steps and clears
  chk_st_load: assert property (
    stLoad |=> desiredSector == $past(writeData[`DSK_SEC_W-1:0])
    && headSelect
      == $past(writeData[`DSK_TRK_LSB+`DSK_TRK_W-1:`DSK_TRK_LSB]))
    else $error("sector/track not loaded");
  chk_trk_step: assert property (
    !stLoad && trackAdvance && !finalTrackDetect
    |=> headSelect == $past(headSelect) + `DSK_TRK_ONE)
    else $error("track not advanced");
  chk_trk_wrap: assert property (
    !stLoad && trackAdvance && finalTrackDetect
    |=> headSelect == `DSK_TRK_ZERO && seekGo)
    else $error("track did not wrap");
  chk_sec_step: assert property (
    !stLoad && commandInProgress && endOfBlockPulse && !trackAdvance
    |=> desiredSector == $past(desiredSector) + `DSK_SEC_ONE)
    else $error("sector not advanced");
  chk_sec_clear: assert property (
    !stLoad && trackAdvance |=> desiredSector == `DSK_SEC_ZERO)
    else $error("sector not cleared");
  // Gap end closes the sector and pulses end-of-block
  chk_eob_flags: assert property (
    dataGapEnd && !sectorAreaStart |=> endOfBlockPulse && !sectorAreaFlag)
    else $error("data gap end not handled");
  chk_wr_flag: assert property (
    dataGapEnd && writeOp && !writeSectorStart |=> !writeSectorFlag)
    else $error("write sector flag not cleared");
  // Main scenarios: seek lands, reverse, step, offset, overflow
  cov_seek: cover property (readyRise ##3 cylindersEqual);
  cov_rev: cover property (seekDirectionReverse);
  cov_cyl_step: cover property (seekGo);
  cov_offset: cover property (offsetSelect ##1 offsetSelect);
  cov_ovf: cover property ($rose(errorFlags.addrOverflow));
endmodule : dsk_seek
`default_nettype wire

// [rtl/dsk_seek_map.svh]
`ifndef DSK_SEEK_MAP_SVH
`define DSK_SEEK_MAP_SVH
// Cylinder address width and highest valid cylinder
`define DSK_CYL_W 9
`define DSK_CYL_MAX 9'h19a
// Track and sector field widths
`define DSK_TRK_W 5
`define DSK_SEC_W 5
// Highest track of a cylinder
`define DSK_TRK_LAST 5'h12
// Zero values used for clears
`define DSK_CYL_ZERO 9'h000
`define DSK_TRK_ZERO 5'h00
`define DSK_SEC_ZERO 5'h00
// Write data bus width
`define DSK_WD_W 16
// Track field position in the sector/track word
`define DSK_TRK_LSB 8
// Step sizes for the address counters
`define DSK_CYL_ONE 9'h001
`define DSK_TRK_ONE 5'h01
`define DSK_SEC_ONE 5'h01
// Zero subtract result, borrow bit included
`define DSK_DIFF_ZERO 10'h000
`endif

// [rtl/dsk_seek_pkg.sv]
`include "dsk_seek_map.svh"
package dsk_seek_pkg;
  // Desired sector/track register contents
  typedef struct packed {
    logic [`DSK_TRK_W-1:0] track;
    logic [`DSK_SEC_W-1:0] sector;
  } dsk_sectrk_t;
  // Error flags
  typedef struct packed {
    logic addrOverflow;
    logic invalidAddr;
  } dsk_err_t;
endpackage : dsk_seek_pkg

// [sim/dsk_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Drive mechanism: drops ready while the heads travel to a new cylinder
module dsk_drive_model #(
  parameter int TRAVEL = 12
) (
  input wire logic sys_clk,
  input wire logic [8:0] cylinderDifference,
  input wire logic cylindersEqual,
  output logic driveReadyPin
);
  int cnt; // Travel cycles left
  logic armed; // Rearmed once heads sit on cylinder
  initial begin
    driveReadyPin = 1'b1;
    cnt = 0;
    armed = 1'b1;
  end
  // One seek per new difference; rearm only on cylinder
  always @(posedge sys_clk) begin
    if (cnt > 0) begin
      cnt <= cnt - 1;
      driveReadyPin <= (cnt == 1);
    end else if (cylindersEqual === 1'b1) begin
      armed <= 1'b1;
    end else if (armed && cylinderDifference != 9'h000) begin
      armed <= 1'b0;
      driveReadyPin <= 1'b0;
      cnt <= TRAVEL;
    end
  end
endmodule : dsk_drive_model
`default_nettype wire

// [sim/dsk_seek_test.sv]
`timescale 1ns/1ps
`default_nettype none
// Bench for the seek logic; the drive model answers every seek
module dsk_seek_test;
  import dsk_seek_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  // Stimulus, driven on falling edges
  logic desiredCylinderSelect, sectorTrackSelect, registerWriteStrobe;
  logic commandInProgress, offsetSelect, transferDone, dataGapEnd;
  logic writeOp, sectorAreaStart, writeSectorStart, finalSectorOfTrack;
  logic headerWord1Valid, headerWord2Valid, errorClear, driveReadyPin;
  logic [15:0] writeData, headerWord;
  logic [8:0] offsetValue, cylinderDifference, desiredCylinder;
  logic [8:0] currentCylinder;
  logic [4:0] sectorCount, headSelect, desiredSector;
  // Results from the block
  logic seekDirectionReverse, cylindersEqual, sectorFoundEnable, seekGo;
  logic currentCylinderLoadClock, finalTrackDetect, cylinderMatch;
  logic sectorTrackMatch, sectorMatch, endOfBlockPulse;
  logic sectorAreaFlag, writeSectorFlag;
  dsk_err_t errorFlags;
  int bad_count = 0;
  int tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  dsk_seek dsk_seek_inst (.*);
  dsk_drive_model dsk_drive_model_inst (.*);
  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask : pulse
  // Register write; the idle cycle after keeps strobes apart
  task automatic wr(input logic cyl, input logic [15:0] d);
    desiredCylinderSelect = cyl;
    sectorTrackSelect = !cyl;
    registerWriteStrobe = 1'b1;
    writeData = d;
    tick();
    {desiredCylinderSelect, sectorTrackSelect, registerWriteStrobe} = '0;
    tick();
  endtask : wr
  // Wait for the seek to land, counting load pulses on the way
  task automatic settle();
    int i;
    int n;
    n = 0;
    for (i = 0; i < 300; i++) begin
      if (cylindersEqual === 1'b1 && currentCylinder === desiredCylinder)
        break;
      n += (currentCylinderLoadClock === 1'b1);
      tick();
    end
    if (i == 300) begin
      $display("MISMATCH settle expected landed seen timeout");
      bad_count++;
      conclude();
    end
    chk("loadPulses", 16'h0001, 16'(n));
    chk("diffZero", 16'h0000, cylinderDifference);
    chk("foundEn", 16'h0001, sectorFoundEnable);
  endtask : settle
  // One sector end with the gap pulse; go is seekGo as the step lands
  task automatic step(input logic fin, output logic go);
    commandInProgress = 1'b1;
    finalSectorOfTrack = fin;
    dataGapEnd = 1'b1;
    tick();
    dataGapEnd = 1'b0;
    chk("eob", 16'h0001, endOfBlockPulse);
    tick();
    go = seekGo;
    finalSectorOfTrack = 1'b0;
    tick();
  endtask : step
  task automatic testSeek();
    chk("rstCyl", 16'h0000, desiredCylinder);
    chk("rstEq", 16'h0001, cylindersEqual);
    chk("rstErr", 16'h0000, errorFlags);
    wr(1'b1, 16'h0005);
    chk("fwdDiff", 16'h0005, cylinderDifference);
    chk("fwdDir", 16'h0000, seekDirectionReverse);
    chk("neq", 16'h0000, cylindersEqual);
    settle();
    wr(1'b1, 16'h0002);
    chk("revDiff", 16'h0003, cylinderDifference);
    chk("revDir", 16'h0001, seekDirectionReverse);
    settle();
    commandInProgress = 1'b1;
    wr(1'b1, 16'h0007);
    chk("busyCyl", 16'h0002, desiredCylinder);
    commandInProgress = 1'b0;
    wr(1'b1, 16'h019a);
    chk("topOk", 16'h0000, errorFlags);
    wr(1'b1, 16'h019b);
    chk("invalid", 16'h0001, errorFlags);
    settle();
    pulse(errorClear);
    chk("errClr", 16'h0000, errorFlags);
    offsetSelect = 1'b1;
    offsetValue = 9'h0aa;
    tick(2);
    chk("offset", 16'h00aa, cylinderDifference);
    offsetSelect = 1'b0;
    $display("seek test done");
  endtask : testSeek
  task automatic testHeader();
    wr(1'b0, 16'h0304);
    chk("head", 16'h0003, headSelect);
    chk("sect", 16'h0004, desiredSector);
    sectorCount = 5'h04;
    headerWord = 16'h019b;
    pulse(headerWord1Valid);
    chk("cylMatch", 16'h0001, cylinderMatch);
    chk("secMatch", 16'h0001, sectorMatch);
    headerWord = 16'h0304;
    pulse(headerWord2Valid);
    chk("stMatch", 16'h0001, sectorTrackMatch);
    headerWord = 16'h0204;
    pulse(headerWord2Valid);
    chk("stMiss", 16'h0000, sectorTrackMatch);
    $display("header test done");
  endtask : testHeader
  task automatic testStep();
    logic go;
    writeOp = 1'b1;
    pulse(sectorAreaStart);
    pulse(writeSectorStart);
    step(1'b0, go);
    chk("secInc", 16'h0005, desiredSector);
    chk("wsFlag", 16'h0000, writeSectorFlag);
    chk("areaFlag", 16'h0000, sectorAreaFlag);
    step(1'b1, go);
    chk("trkInc", 16'h0004, headSelect);
    chk("secClr", 16'h0000, desiredSector);
    chk("noGo", 16'h0000, go);
    // Read side keeps the write flag; transfer end steps the track
    writeOp = 1'b0;
    pulse(writeSectorStart);
    transferDone = 1'b1;
    step(1'b0, go);
    transferDone = 1'b0;
    chk("trkDone", 16'h0005, headSelect);
    chk("wsKeep", 16'h0001, writeSectorFlag);
    commandInProgress = 1'b0;
    wr(1'b1, 16'h019a);
    settle();
    wr(1'b0, 16'h1200);
    chk("trk18", 16'h0001, finalTrackDetect);
    step(1'b1, go);
    chk("trkWrap", 16'h0000, headSelect);
    chk("cylInc", 16'h019b, desiredCylinder);
    chk("go", 16'h0001, go);
    chk("ovf", 16'h0002, errorFlags);
    commandInProgress = 1'b0;
    settle();
    $display("step test done");
  endtask : testStep
  initial begin
    {desiredCylinderSelect, sectorTrackSelect, registerWriteStrobe,
     commandInProgress, offsetSelect, transferDone, dataGapEnd, writeOp,
     sectorAreaStart, writeSectorStart, finalSectorOfTrack,
     headerWord1Valid, headerWord2Valid, errorClear} = '0;
    writeData = '0;
    headerWord = '0;
    offsetValue = '0;
    sectorCount = '0;
    tick(6);
    srst = 1'b0;
    tick();
    testSeek();
    testHeader();
    testStep();
    conclude();
  end
endmodule : dsk_seek_test
`default_nettype wire
